// File: common/nim_consts.vh
// Purpose: Offsets, field positions and reset values for the interrupt gating block.
// Assumes: Registers are 32-bit words at byte offsets on a plain register port.
// Notes:   Included by its bare name.
`ifndef NIM_CONSTS_VH
`define NIM_CONSTS_VH

`define NIM_ADDR_W          8
`define NIM_OFF_EVENTS      8'h10
`define NIM_OFF_MASK        8'h14
`define NIM_OFF_ENABLE      8'h18
`define NIM_MASK_RESET      32'h00000000
`define NIM_ENABLE_RESET    32'h00000000
// Bits that carry a status condition: 28..20, 16, 15, 12, 10..0.
`define NIM_VALID_BITS      32'h1FF197FF
// Latched conditions that arrive from the rest of the chip (15 is derived).
`define NIM_SRC_BITS        32'h1FF117FF
`define NIM_BIT_GLOBAL_ON   0
`define NIM_BIT_SUMMARY     15
`define NIM_HI_LSB          16
`define NIM_HI_MSB          25
// Positions of the individual event sources in the status word.
`define NIM_BIT_WAKE         28
`define NIM_BIT_HOLD_END     27
`define NIM_BIT_HOLD_START   26
`define NIM_BIT_TX_RST_DONE  25
`define NIM_BIT_RX_RST_DONE  24
`define NIM_BIT_PARITY       23
`define NIM_BIT_SYS_ERR      22
`define NIM_BIT_MST_ABORT    21
`define NIM_BIT_TGT_ABORT    20
`define NIM_BIT_RX_STAT_OVF  16
`define NIM_BIT_SW_EVENT     12
`define NIM_BIT_TX_UNDERFLOW 10
`define NIM_BIT_TX_STOPPED   9
`define NIM_BIT_TX_FAILED    8
`define NIM_BIT_TX_ENTRY     7
`define NIM_BIT_TX_GOOD      6
`define NIM_BIT_RX_OVERFLOW  5
`define NIM_BIT_RX_STOPPED   4
`define NIM_BIT_RX_EARLY     3
`define NIM_BIT_RX_FAILED    2
`define NIM_BIT_RX_ENTRY     1
`define NIM_BIT_RX_GOOD      0

`endif

// File: hdl/nim_irq_gate.v
// Purpose: Interrupt gating for the Ethernet controller: latched events, per-source mask, global enable.
// Assumes: Event set pulses are synchronous to core_clk; register port strobes are one cycle long.
// Notes:   Read data stand in the cycle after the read strobe; unmapped addresses read zero.
//          A set pulse in the cycle of a status read survives the clear, so no event is lost.
//          Soft reset clears status, mask and enable; the line drops one cycle later.
//          Reserved status and mask bits always read zero.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "nim_consts.vh"

module nim_irq_gate #(
  parameter DATA_W = 32
) (
  input  wire              core_clk,
  input  wire              resetn,
  input  wire [7:0]        reg_addr,
  input  wire [DATA_W-1:0] reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [DATA_W-1:0] reg_rdata,
  input  wire [DATA_W-1:0] event_set,
  input  wire              soft_reset,
  output reg               host_irq_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] latched_event_register_q;
  reg  [DATA_W-1:0] latched_event_register_d;
  reg  [DATA_W-1:0] interrupt_source_mask_q;
  reg               global_irq_on_q;
  reg  [DATA_W-1:0] rdata_d;
  wire [DATA_W-1:0] status_view;
  wire              rd_events;
  wire              irq_d;
  reg  [DATA_W-1:0] src_set;
  reg  [DATA_W-1:0] status_bits;
  wire [DATA_W-1:0] pending;
  wire              wr_mask;
  wire              wr_enable;
  wire              rd_mask;
  wire              rd_enable;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when the register port address equals the given offset; the caller ANDs in the strobe.
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  // The summary bit folds every high error condition into one flag.
  function summary_of;
    input [DATA_W-1:0] st;
    begin
      summary_of = |st[`NIM_HI_MSB:`NIM_HI_LSB];
    end
  endfunction

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  assign wr_mask   = reg_wr && hit(reg_addr, `NIM_OFF_MASK);
  assign wr_enable = reg_wr && hit(reg_addr, `NIM_OFF_ENABLE);
  assign rd_mask   = reg_rd && hit(reg_addr, `NIM_OFF_MASK);
  assign rd_enable = reg_rd && hit(reg_addr, `NIM_OFF_ENABLE);

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  // Each condition is named once here so the bit map reads in one place.
  // Bits outside the map are dropped, so a stray set pulse can neither
  // latch a reserved bit nor fake the summary bit.
  // Wake and pause conditions.
  wire              wake_event;
  wire              tx_hold_ended;
  wire              tx_hold_started;

  // Reset completion and host bus errors.
  wire              tx_reset_done;
  wire              rx_reset_done;
  wire              bus_parity_fault;
  wire              system_error_signalled;
  wire              master_abort_seen;
  wire              target_abort_seen;

  // Status overflow and software request.
  wire              rx_status_fifo_overflow;
  wire              software_event;

  // Transmit and receive events.
  wire              tx_fifo_underflow;
  wire              tx_engine_stopped;
  wire              tx_frame_failed;
  wire              tx_flagged_entry_done;
  wire              tx_frame_good;
  wire              rx_fifo_overflow;
  wire              rx_engine_stopped;
  wire              rx_early_drain_met;
  wire              rx_frame_failed;
  wire              rx_flagged_entry_done;
  wire              rx_frame_good;

  // Wake and pause conditions.
  assign wake_event              = event_set[`NIM_BIT_WAKE];
  assign tx_hold_ended           = event_set[`NIM_BIT_HOLD_END];
  assign tx_hold_started         = event_set[`NIM_BIT_HOLD_START];

  // Reset completion and host bus errors.
  assign tx_reset_done           = event_set[`NIM_BIT_TX_RST_DONE];
  assign rx_reset_done           = event_set[`NIM_BIT_RX_RST_DONE];
  assign bus_parity_fault        = event_set[`NIM_BIT_PARITY];
  assign system_error_signalled  = event_set[`NIM_BIT_SYS_ERR];
  assign master_abort_seen       = event_set[`NIM_BIT_MST_ABORT];
  assign target_abort_seen       = event_set[`NIM_BIT_TGT_ABORT];

  // Status overflow and software request.
  assign rx_status_fifo_overflow = event_set[`NIM_BIT_RX_STAT_OVF];
  assign software_event          = event_set[`NIM_BIT_SW_EVENT];

  // Transmit and receive events.
  assign tx_fifo_underflow       = event_set[`NIM_BIT_TX_UNDERFLOW];
  assign tx_engine_stopped       = event_set[`NIM_BIT_TX_STOPPED];
  assign tx_frame_failed         = event_set[`NIM_BIT_TX_FAILED];
  assign tx_flagged_entry_done   = event_set[`NIM_BIT_TX_ENTRY];
  assign tx_frame_good           = event_set[`NIM_BIT_TX_GOOD];
  assign rx_fifo_overflow        = event_set[`NIM_BIT_RX_OVERFLOW];
  assign rx_engine_stopped       = event_set[`NIM_BIT_RX_STOPPED];
  assign rx_early_drain_met      = event_set[`NIM_BIT_RX_EARLY];
  assign rx_frame_failed         = event_set[`NIM_BIT_RX_FAILED];
  assign rx_flagged_entry_done   = event_set[`NIM_BIT_RX_ENTRY];
  assign rx_frame_good           = event_set[`NIM_BIT_RX_GOOD];

  always @* begin
    src_set = {DATA_W{1'b0}};
    // Wake and pause conditions.
    src_set[`NIM_BIT_WAKE]         = wake_event;
    src_set[`NIM_BIT_HOLD_END]     = tx_hold_ended;
    src_set[`NIM_BIT_HOLD_START]   = tx_hold_started;

    // Reset completion and host bus errors.
    src_set[`NIM_BIT_TX_RST_DONE]  = tx_reset_done;
    src_set[`NIM_BIT_RX_RST_DONE]  = rx_reset_done;
    src_set[`NIM_BIT_PARITY]       = bus_parity_fault;
    src_set[`NIM_BIT_SYS_ERR]      = system_error_signalled;
    src_set[`NIM_BIT_MST_ABORT]    = master_abort_seen;
    src_set[`NIM_BIT_TGT_ABORT]    = target_abort_seen;

    // Status overflow and software request.
    src_set[`NIM_BIT_RX_STAT_OVF]  = rx_status_fifo_overflow;
    src_set[`NIM_BIT_SW_EVENT]     = software_event;

    // Transmit and receive events.
    src_set[`NIM_BIT_TX_UNDERFLOW] = tx_fifo_underflow;
    src_set[`NIM_BIT_TX_STOPPED]   = tx_engine_stopped;
    src_set[`NIM_BIT_TX_FAILED]    = tx_frame_failed;
    src_set[`NIM_BIT_TX_ENTRY]     = tx_flagged_entry_done;
    src_set[`NIM_BIT_TX_GOOD]      = tx_frame_good;
    src_set[`NIM_BIT_RX_OVERFLOW]  = rx_fifo_overflow;
    src_set[`NIM_BIT_RX_STOPPED]   = rx_engine_stopped;
    src_set[`NIM_BIT_RX_EARLY]     = rx_early_drain_met;
    src_set[`NIM_BIT_RX_FAILED]    = rx_frame_failed;
    src_set[`NIM_BIT_RX_ENTRY]     = rx_flagged_entry_done;
    src_set[`NIM_BIT_RX_GOOD]      = rx_frame_good;
  end

  // ----------------------------------------------------------------
  // Latched events
  // ----------------------------------------------------------------
  assign rd_events = reg_rd && hit(reg_addr, `NIM_OFF_EVENTS);

  // Reserved positions are forced to zero here, and the summary bit is
  // derived from the latched high bits so it can never disagree with
  // them, including the cycle in which a read clears them.
  always @* begin
    status_bits = {DATA_W{1'b0}};
    // Wake and pause conditions.
    status_bits[`NIM_BIT_WAKE]         = latched_event_register_q[`NIM_BIT_WAKE];
    status_bits[`NIM_BIT_HOLD_END]     = latched_event_register_q[`NIM_BIT_HOLD_END];
    status_bits[`NIM_BIT_HOLD_START]   = latched_event_register_q[`NIM_BIT_HOLD_START];

    // Reset completion and host bus errors.
    status_bits[`NIM_BIT_TX_RST_DONE]  = latched_event_register_q[`NIM_BIT_TX_RST_DONE];
    status_bits[`NIM_BIT_RX_RST_DONE]  = latched_event_register_q[`NIM_BIT_RX_RST_DONE];
    status_bits[`NIM_BIT_PARITY]       = latched_event_register_q[`NIM_BIT_PARITY];
    status_bits[`NIM_BIT_SYS_ERR]      = latched_event_register_q[`NIM_BIT_SYS_ERR];
    status_bits[`NIM_BIT_MST_ABORT]    = latched_event_register_q[`NIM_BIT_MST_ABORT];
    status_bits[`NIM_BIT_TGT_ABORT]    = latched_event_register_q[`NIM_BIT_TGT_ABORT];

    // Status overflow and software request.
    status_bits[`NIM_BIT_RX_STAT_OVF]  = latched_event_register_q[`NIM_BIT_RX_STAT_OVF];
    status_bits[`NIM_BIT_SW_EVENT]     = latched_event_register_q[`NIM_BIT_SW_EVENT];

    // Transmit and receive events.
    status_bits[`NIM_BIT_TX_UNDERFLOW] = latched_event_register_q[`NIM_BIT_TX_UNDERFLOW];
    status_bits[`NIM_BIT_TX_STOPPED]   = latched_event_register_q[`NIM_BIT_TX_STOPPED];
    status_bits[`NIM_BIT_TX_FAILED]    = latched_event_register_q[`NIM_BIT_TX_FAILED];
    status_bits[`NIM_BIT_TX_ENTRY]     = latched_event_register_q[`NIM_BIT_TX_ENTRY];
    status_bits[`NIM_BIT_TX_GOOD]      = latched_event_register_q[`NIM_BIT_TX_GOOD];
    status_bits[`NIM_BIT_RX_OVERFLOW]  = latched_event_register_q[`NIM_BIT_RX_OVERFLOW];
    status_bits[`NIM_BIT_RX_STOPPED]   = latched_event_register_q[`NIM_BIT_RX_STOPPED];
    status_bits[`NIM_BIT_RX_EARLY]     = latched_event_register_q[`NIM_BIT_RX_EARLY];
    status_bits[`NIM_BIT_RX_FAILED]    = latched_event_register_q[`NIM_BIT_RX_FAILED];
    status_bits[`NIM_BIT_RX_ENTRY]     = latched_event_register_q[`NIM_BIT_RX_ENTRY];
    status_bits[`NIM_BIT_RX_GOOD]      = latched_event_register_q[`NIM_BIT_RX_GOOD];
    status_bits[`NIM_BIT_SUMMARY]      = summary_of(latched_event_register_q);
  end
  assign status_view = status_bits;

  always @* begin
    latched_event_register_d = latched_event_register_q;
    if (rd_events) begin
      latched_event_register_d = {DATA_W{1'b0}};
    end
    // A new event in the clearing cycle survives the read.
    latched_event_register_d = latched_event_register_d | src_set;
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      latched_event_register_q <= {DATA_W{1'b0}};
    end else if (soft_reset) begin
      latched_event_register_q <= {DATA_W{1'b0}};
    end else begin
      latched_event_register_q <= latched_event_register_d;
    end
  end

  // ----------------------------------------------------------------
  // Mask and global enable
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_source_mask_q <= `NIM_MASK_RESET;
    end else if (soft_reset) begin
      interrupt_source_mask_q <= `NIM_MASK_RESET;
    end else if (wr_mask) begin
      interrupt_source_mask_q <= reg_wdata & `NIM_VALID_BITS;
    end
  end

  // Only bit 0 is stored, so one plain write turns the line on or off
  // without a read-modify-write; status and mask are untouched by it.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      global_irq_on_q <= 1'b0;
    end else if (soft_reset) begin
      global_irq_on_q <= 1'b0;
    end else if (wr_enable) begin
      global_irq_on_q <= reg_wdata[`NIM_BIT_GLOBAL_ON];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  // Each mask bit ANDs the status bit in the same position.
  assign pending = status_view & interrupt_source_mask_q;
  // The enable only gates the line; pending status is kept while it is off.
  assign irq_d   = global_irq_on_q && |pending;

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      host_irq_out <= 1'b0;
    end else begin
      host_irq_out <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = {DATA_W{1'b0}};
    if (rd_events) begin
      rdata_d = status_view;
    end else if (rd_mask) begin
      rdata_d = interrupt_source_mask_q;
    end else if (rd_enable) begin
      rdata_d = {{(DATA_W-1){1'b0}}, global_irq_on_q};
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= {DATA_W{1'b0}};
    end else begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// File: testbench/nim_irq_gate_assertions.sv
// Purpose: port checks. Assumes: one clock. Notes: bound below.
`timescale 1ns/1ps
module nim_chk (
  input wire        core_clk,
  input wire        resetn,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire        soft_reset,
  input wire        host_irq_out,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire [31:0] event_set
);
  wire rs = reg_rd && reg_addr == 8'h10;
  wire quiet = event_set == 32'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_idl; !$past(reg_rd) |-> !reg_rdata; endproperty
  a_idl: assert property (p_idl) else $error("rdata idle");
  property p_en; $past(reg_rd && reg_addr == 8'h18) |-> !reg_rdata[31:1]; endproperty
  a_en: assert property (p_en) else $error("enable bits");
  property p_msk; $past(reg_rd && reg_addr == 8'h14) |-> !(reg_rdata & ~32'h1FF197FF); endproperty
  a_msk: assert property (p_msk) else $error("mask bits");
  property p_sum; $past(rs) |-> reg_rdata[15] == |reg_rdata[25:16]; endproperty
  a_sum: assert property (p_sum) else $error("summary");
  property p_clr; rs && quiet ##1 quiet ##1 rs |-> ##1 !reg_rdata; endproperty
  a_clr: assert property (p_clr) else $error("status kept");
  property p_off; reg_wr && reg_addr == 8'h18 && !reg_wdata[0] ##1 !reg_wr |-> ##1 !host_irq_out; endproperty
  a_off: assert property (p_off) else $error("irq while off");
  property p_mz; reg_wr && reg_addr == 8'h14 && !reg_wdata |-> ##2 !host_irq_out; endproperty
  a_mz: assert property (p_mz) else $error("irq masked");
  property p_sr; soft_reset |-> ##2 !host_irq_out; endproperty
  a_sr: assert property (p_sr) else $error("irq after reset");
endmodule
bind nim_irq_gate nim_chk u_chk (
  .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .soft_reset(soft_reset), .host_irq_out(host_irq_out), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .event_set(event_set)
);

// File: testbench/nim_host.sv
// Purpose: host irq sink. Assumes: level irq. Notes: latches any request.
`timescale 1ns/1ps
module nim_host (
  input  wire core_clk,
  input  wire host_irq_out,
  output reg  seen_q
);
  initial seen_q = 1'b0;
  always @(posedge core_clk) if (host_irq_out) seen_q <= 1'b1;
endmodule

// File: testbench/nim_irq_gate_tb.sv
// Purpose: random and corner tests. Assumes: 25 ns clock. Notes: seed 27.
`timescale 1ns/1ps
module nim_irq_gate_tb;
  reg core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, soft_reset = 0;
  reg [7:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0, event_set = 0, m, s;
  wire [31:0] reg_rdata;
  wire host_irq_out, seen;
  integer n_fail = 0, cmp_count = 0, cyc = 0, i;
  always #12.5 core_clk = ~core_clk;
  nim_irq_gate dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_set(event_set),
    .soft_reset(soft_reset), .host_irq_out(host_irq_out)
  );
  nim_host host (.core_clk(core_clk), .host_irq_out(host_irq_out), .seen_q(seen));
  function [31:0] stat(input [31:0] v);
    stat = v & 32'h1FF117FF | {16'h0, |(v[25:16] & 10'h3F1), 15'h0};
  endfunction
  task chk(input [63:0] nm, input [31:0] exp, got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // Read data stand one cycle only, so the check sits right after the taking edge.
  task bus(input w, input [7:0] a, input [31:0] d, exp);
    begin
      @(posedge core_clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
      @(posedge core_clk);
      {reg_wr, reg_rd} <= 2'b00;
      #1 if (!w) chk("rdata", exp, reg_rdata);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  initial begin
    i = $urandom(27);
    repeat (3) @(posedge core_clk);
    resetn <= 1;
    bus(0, 8'h14, 0, 0);
    for (i = 0; i < 12; i = i + 1) begin
      m = i < 2 ? -i : $urandom;
      s = i < 2 ? -1 : $urandom;
      bus(1, 8'h14, m, 0);
      bus(1, 8'h18, 1, 0);
      @(posedge core_clk) event_set <= s;
      @(posedge core_clk) event_set <= 0;
      s = stat(s);
      @(posedge core_clk) #1 chk("irq", |(s & m), host_irq_out);
      bus(1, 8'h18, -2, 0);
      repeat (2) @(posedge core_clk);
      #1 chk("irq off", 0, host_irq_out);
      bus(0, 8'h14, 0, m & 32'h1FF197FF);
      bus(0, 8'h10, 0, s);
      bus(0, 8'h10, 0, 0);
    end
    bus(1, 8'h18, -1, 0);
    bus(0, 8'h18, 0, 1);
    bus(0, 8'h1C, 0, 0);
    bus(1, 8'h14, -1, 0);
    @(posedge core_clk) soft_reset <= 1;
    @(posedge core_clk) soft_reset <= 0;
    bus(0, 8'h14, 0, 0);
    bus(1, 8'h14, -1, 0);
    @(posedge core_clk) resetn <= 0;
    @(posedge core_clk) resetn <= 1;
    bus(0, 8'h14, 0, 0);
    chk("host", 1, seen);
    end_of_test;
  end
endmodule
